/* hw/timer_io_control_capture_compare.v */
// I/O control registers and capture/compare pin logic of a five-channel timer.
`timescale 1ns/1ps
`default_nettype none
`include "timer_io_map.vh"
module timer_io_control_capture_compare #(
    parameter CW = 16
) (
    input  wire            clk_i,
    input  wire            rst_i,
    input  wire            ce_i,
    input  wire            wb_cyc_i,
    input  wire            wb_stb_i,
    input  wire            wb_we_i,
    input  wire [7:0]      wb_adr_i,
    input  wire [3:0]      wb_sel_i,
    input  wire [31:0]     wb_dat_i,
    output reg  [31:0]     wb_dat_o,
    output reg             wb_ack_o,
    input  wire [5*CW-1:0] cnt_i,
    input  wire            ch1_count_i,
    input  wire [15:0]     pin_i,
    output wire [15:0]     pin_o,
    output wire [15:0]     pin_oe_o,
    output reg  [4:0]      counter_start_o,
    output reg  [15:0]     flag_o
);
    // Unit order: ch0 A-D, ch1 A-B, ch2 A-B, ch3 A-D, ch4 A-D.
    function [2:0] unit_chan;
        input [3:0] u;
        begin
            if (u < 4'd4)
                unit_chan = 3'd0;
            else if (u < 4'd6)
                unit_chan = 3'd1;
            else if (u < 4'd8)
                unit_chan = 3'd2;
            else if (u < 4'd12)
                unit_chan = 3'd3;
            else
                unit_chan = 3'd4;
        end
    endfunction

    // Slot 0 to 3 stands for the first to fourth general register.
    function [1:0] unit_slot;
        input [3:0] u;
        begin
            if (u >= 4'd4 && u < 4'd8)
                unit_slot = {1'b0, u[0]};
            else
                unit_slot = u[1:0];
        end
    endfunction

    // High registers sit at index 0-4 by channel, low ones at 5-7.
    function [2:0] io_index;
        input [2:0] ch;
        input [1:0] slot;
        begin
            if (!slot[1])
                io_index = ch;
            else if (ch == 3'd0)
                io_index = 3'd5;
            else if (ch == 3'd3)
                io_index = 3'd6;
            else
                io_index = 3'd7;
        end
    endfunction

    function [7:0] byte_merge;
        input [7:0] old;
        input [7:0] nw;
        input       en;
        begin
            byte_merge = en ? nw : old;
        end
    endfunction

    reg  [7:0]    io_ctl [0:7];
    reg  [7:0]    mode   [0:4];
    reg  [CW-1:0] gr     [0:15];
    wire [15:0]   pin_sync;
    wire [15:0]   match;
    wire [15:0]   capture;
    wire [63:0]   code_bus;
    wire [15:0]   blocked;
    wire [15:0]   buffered;
    wire [16*CW-1:0] next_all;

    wire       req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wr      = req & wb_we_i;
    wire [7:0] adr     = {wb_adr_i[7:2], 2'b00};
    wire       hit_io  = (adr <= `IO_CTL_LAST);
    wire       hit_md  = (adr >= `MODE_BASE) && (adr <= `MODE_LAST);
    wire       hit_st  = (adr == `START_ADDR);
    wire       hit_fl  = (adr == `FLAG_ADDR);
    wire       hit_gr  = (adr >= `GR_BASE) && (adr <= `GR_LAST);
    wire [7:0] md_off  = adr - `MODE_BASE;
    wire [2:0] io_idx  = adr[4:2];
    wire [2:0] md_idx  = md_off[4:2];
    wire [3:0] gr_idx  = adr[5:2];

    pin_sync #(
        .W (16)
    ) u_pin_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   (pin_i),
        .q_o   (pin_sync)
    );

    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : unit
            localparam [2:0] CH   = unit_chan(g);
            localparam [1:0] SL   = unit_slot(g);
            localparam [2:0] IDX  = io_index(CH, SL);
            localparam       BUFB = SL[0] ? `BUF_SECOND_BIT : `BUF_FIRST_BIT;
            wire [7:0] ctl  = io_ctl[IDX];
            wire [7:0] md   = mode[CH];
            wire       pwm2 = (CH < 3'd3) && (md[3:0] == `MODE_PWM2);

            // Field halves of high and low registers.
            assign code_bus[4*g +: 4] = SL[0] ?
                ctl[`FIELD_HI_LSB +: 4] : ctl[`FIELD_LO_LSB +: 4];
            assign blocked[g]  = SL[1] & md[BUFB];
            assign buffered[g] = ~SL[1] & md[BUFB];

            gr_channel_unit #(
                .CW     (CW),
                .IS_CH0 (CH == 3'd0 ? 1 : 0)
            ) u_unit (
                .clk_i       (clk_i),
                .rst_i       (rst_i),
                .ce_i        (ce_i),
                .code_i      (code_bus[4*g +: 4]),
                .blocked_i   (blocked[g]),
                .running_i   (counter_start_o[CH]),
                .pwm2_i      (pwm2),
                .cnt_i       (cnt_i[CH*CW +: CW]),
                .gr_i        (gr[g]),
                .pin_sync_i  (pin_sync[g]),
                .ch1_count_i (ch1_count_i),
                .pin_o       (pin_o[g]),
                .pin_oe_o    (pin_oe_o[g]),
                .match_o     (match[g]),
                .capture_o   (capture[g])
            );

            // Next value of this general register. Bus writes lose to
            // captures and buffer transfers, since a lost capture edge
            // cannot be repaired by software.
            localparam [3:0] GI = g;
            wire [CW-1:0] own   = gr[g];
            wire          wr_me = wr && hit_gr && (gr_idx == GI);
            wire [CW-1:0] merged;

            assign merged[7:0]  = byte_merge(own[7:0], wb_dat_i[7:0],
                                             wb_sel_i[0]);
            assign merged[15:8] = byte_merge(own[15:8], wb_dat_i[15:8],
                                             wb_sel_i[1]);

            if (SL[1]) begin : third_fourth
                reg [CW-1:0] next_gr;

                // A buffering register takes the old first or second value
                // each time its partner captures.
                always @* begin
                    next_gr = own;
                    if (wr_me) begin
                        next_gr = merged;
                    end
                    if (capture[g]) begin
                        next_gr = cnt_i[CH*CW +: CW];
                    end else if (capture[g-2] && buffered[g-2]) begin
                        next_gr = gr[g-2];
                    end
                end

                assign next_all[g*CW +: CW] = next_gr;
            end else begin : first_second
                reg [CW-1:0] next_gr;

                // A compare match reloads the register from its buffer.
                always @* begin
                    next_gr = own;
                    if (wr_me) begin
                        next_gr = merged;
                    end
                    if (capture[g]) begin
                        next_gr = cnt_i[CH*CW +: CW];
                    end else if (match[g] && buffered[g]) begin
                        next_gr = gr[g+2];
                    end
                end

                assign next_all[g*CW +: CW] = next_gr;
            end
        end
    endgenerate

    integer i;
    integer k;

    // Control registers; bus writes land on the edge that raises ack.
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (i = 0; i < 8; i = i + 1)
                io_ctl[i] <= `IO_CTL_RESET;
            for (i = 0; i < 5; i = i + 1)
                mode[i] <= `MODE_RESET;
            counter_start_o <= `START_RESET;
        end else if (ce_i && wr && wb_sel_i[0]) begin
            if (hit_io) begin
                io_ctl[io_idx] <= wb_dat_i[7:0];
            end else if (hit_md && md_idx < 3'd5) begin
                // Channels 1 and 2 have no buffer pairs.
                if (md_idx == 3'd1 || md_idx == 3'd2)
                    mode[md_idx] <= `MODE_FIXED_ONES |
                                    {4'h0, wb_dat_i[3:0]};
                else
                    mode[md_idx] <= `MODE_FIXED_ONES |
                                    {2'b00, wb_dat_i[5:0]};
            end else if (hit_st) begin
                counter_start_o <= wb_dat_i[4:0];
            end
        end
    end

    // General registers, all loaded from their per-unit next values.
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (k = 0; k < 16; k = k + 1) begin
                gr[k] <= `GR_RESET;
            end
        end else if (ce_i) begin
            for (k = 0; k < 16; k = k + 1) begin
                gr[k] <= next_all[k*CW +: CW];
            end
        end
    end

    // Capture/compare flags clear by writing one; a new event wins, so
    // software clearing a stale flag can never hide a fresh event.
    wire [15:0] sel_mask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [15:0] clr_mask  = (wr && hit_fl) ? (wb_dat_i[15:0] & sel_mask)
                                           : 16'h0000;
    wire [15:0] next_flag = (flag_o & ~clr_mask) | capture | match;

    always @(posedge clk_i) begin
        if (rst_i) begin
            flag_o <= `FLAG_RESET;
        end else if (ce_i) begin
            flag_o <= next_flag;
        end
    end

    // Read data for the addressed register; unmapped words read zero.
    reg [31:0] next_dat;

    always @* begin
        next_dat = 32'h00000000;
        if (hit_io) begin
            next_dat = {24'h000000, io_ctl[io_idx]};
        end else if (hit_md && md_idx < 3'd5) begin
            next_dat = {24'h000000, mode[md_idx]};
        end else if (hit_st) begin
            next_dat = {27'h0000000, counter_start_o};
        end else if (hit_fl) begin
            next_dat = {16'h0000, flag_o};
        end else if (hit_gr) begin
            next_dat = {{(32-CW){1'b0}}, gr[gr_idx]};
        end
    end

    // Bus answer: one wait state, ack high for exactly one cycle.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            wb_ack_o <= req;
            // Read data stays put between reads, so a late sampler on the
            // ack cycle still sees the answer it asked for.
            if (req && !wb_we_i) begin
                wb_dat_o <= next_dat;
            end
        end
    end
endmodule // timer_io_control_capture_compare
`default_nettype wire

/* hw/timer_io_map.vh */
// Register offsets, field positions and codes of the timer I/O control block.
`ifndef TIMER_IO_MAP_VH
`define TIMER_IO_MAP_VH

`define IO_CTL_BASE      8'h00
`define IO_CTL_LAST      8'h1c
`define MODE_BASE        8'h20
`define MODE_LAST        8'h30
`define START_ADDR       8'h34
`define FLAG_ADDR        8'h38
`define GR_BASE          8'h40
`define GR_LAST          8'h7c

`define IO_CTL_RESET     8'h00
`define MODE_RESET       8'hc0
`define MODE_FIXED_ONES  8'hc0
`define START_RESET      5'h00
`define FLAG_RESET       16'h0000
`define GR_RESET         16'hffff

`define FIELD_LO_LSB     0
`define FIELD_HI_LSB     4
`define BUF_FIRST_BIT    4
`define BUF_SECOND_BIT   5
`define MODE_PWM2        4'h3

`define CODE_HOLD_LO     2'h0
`define CODE_DRIVE_0     2'h1
`define CODE_DRIVE_1     2'h2
`define CODE_TOGGLE      2'h3
`define CODE_CAP_RISE    4'h8
`define CODE_CAP_FALL    4'h9
`define CODE_CAP_BOTH    3'h5
`define CODE_CAP_CH1     2'h3

`endif

/* hw/pin_sync.v */
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter W = 16
) (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire         ce_i,
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] meta;

    always @(posedge clk_i) begin
        if (rst_i) begin
            meta <= {W{1'b0}};
            q_o  <= {W{1'b0}};
        end else if (ce_i) begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule // pin_sync
`default_nettype wire

/* hw/gr_channel_unit.v */
// Pin action and capture event logic for one general register.
`timescale 1ns/1ps
`default_nettype none
`include "timer_io_map.vh"
module gr_channel_unit #(
    parameter CW     = 16,
    parameter IS_CH0 = 0
) (
    input  wire          clk_i,
    input  wire          rst_i,
    input  wire          ce_i,
    input  wire [3:0]    code_i,
    input  wire          blocked_i,
    input  wire          running_i,
    input  wire          pwm2_i,
    input  wire [CW-1:0] cnt_i,
    input  wire [CW-1:0] gr_i,
    input  wire          pin_sync_i,
    input  wire          ch1_count_i,
    output reg           pin_o,
    output reg           pin_oe_o,
    output wire          match_o,
    output wire          capture_o
);
    reg  pin_prev;
    wire is_output = ~code_i[3];
    wire rise      = pin_sync_i & ~pin_prev;
    wire fall      = ~pin_sync_i & pin_prev;
    reg  cap_event;

    // A buffering register never matches and never captures.
    assign match_o = running_i & is_output & ~blocked_i &
                     (cnt_i == gr_i);

    always @* begin
        cap_event = 1'b0;
        if (code_i == `CODE_CAP_RISE)
            cap_event = rise;
        else if (code_i == `CODE_CAP_FALL)
            cap_event = fall;
        else if (code_i[3:1] == `CODE_CAP_BOTH)
            cap_event = rise | fall;
        else if (code_i[3:2] == `CODE_CAP_CH1 && IS_CH0 != 0)
            cap_event = ch1_count_i;
    end

    assign capture_o = cap_event & ~blocked_i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_prev <= 1'b0;
            pin_o    <= 1'b0;
            pin_oe_o <= 1'b1;
        end else if (ce_i) begin
            pin_prev <= pin_sync_i;
            pin_oe_o <= is_output;
            if (is_output && code_i[1:0] != `CODE_HOLD_LO) begin
                if (!running_i) begin
                    pin_o <= code_i[2];
                end else if (pwm2_i && cnt_i == {CW{1'b0}}) begin
                    pin_o <= code_i[2];
                end else if (match_o) begin
                    case (code_i[1:0])
                        `CODE_DRIVE_0: pin_o <= 1'b0;
                        `CODE_DRIVE_1: pin_o <= 1'b1;
                        default:       pin_o <= ~pin_o;
                    endcase
                end
            end
        end
    end
endmodule // gr_channel_unit
`default_nettype wire

/* verif/pin_far_end.sv */
// Far-side pin model: drives pins the block releases, sees those it drives.
`timescale 1ns/1ps
`default_nettype none
module pin_far_end (
    input  wire logic [15:0] pin_o,
    input  wire logic [15:0] pin_oe_o,
    input  wire logic [15:0] ext_i,
    output wire logic [15:0] pin_i
);
    // A driven pin reads back its own level; a released one the outside.
    assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_i);
endmodule // pin_far_end
`default_nettype wire

/* verif/timer_io_props.sv */
// Port assertions of the timer I/O control block.
`timescale 1ns/1ps
`default_nettype none
module timer_io_props #(
    parameter CW = 16
) (
    input wire logic            clk_i,
    input wire logic            rst_i,
    input wire logic            ce_i,
    input wire logic            wb_cyc_i,
    input wire logic            wb_stb_i,
    input wire logic            wb_we_i,
    input wire logic [7:0]      wb_adr_i,
    input wire logic [3:0]      wb_sel_i,
    input wire logic [31:0]     wb_dat_i,
    input wire logic [31:0]     wb_dat_o,
    input wire logic            wb_ack_o,
    input wire logic [5*CW-1:0] cnt_i,
    input wire logic            ch1_count_i,
    input wire logic [15:0]     pin_i,
    input wire logic [15:0]     pin_o,
    input wire logic [15:0]     pin_oe_o,
    input wire logic [4:0]      counter_start_o,
    input wire logic [15:0]     flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence wr_ack(a);
        wb_ack_o && wb_we_i && wb_adr_i == a;
    endsequence
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
        else $error("no ack one cycle after request");
    reset_state_a: assert property ($past(rst_i) |-> flag_o == 0 &&
        pin_o == 0 && counter_start_o == 0 && !wb_ack_o)
        else $error("state after reset wrong");
    oe_code_a: assert property (wr_ack(8'h00) |=>
        pin_oe_o[0] == !$past(wb_dat_i[3]))
        else $error("pin enable does not follow code");
    flag_clear_a: assert property (($past(flag_o) & ~flag_o) != 0 |->
        $past(wb_we_i && wb_adr_i == 8'h38))
        else $error("flag dropped without clear");
    capture_delay_a: assert property ($rose(flag_o[4]) && !pin_oe_o[4] |->
        $past(pin_i[4], 3) != $past(pin_i[4], 4))
        else $error("capture flag without pin edge");
    match_pin_a: assert property ($changed(pin_o[4]) &&
        $past(counter_start_o[1]) |-> flag_o[4])
        else $error("pin moved without match");
    stop_hold_a: assert property ($changed(pin_o[4]) &&
        !$past(counter_start_o[1]) |-> $past(wb_ack_o) ||
        $past(wb_ack_o, 2)) else $error("stopped pin moved");
endmodule // timer_io_props
bind timer_io_control_capture_compare timer_io_props #(.CW(CW))
    timer_io_props_inst (.*);
`default_nettype wire

/* verif/testbench.sv */
// Register-level test of the timer I/O control block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_i = 0;
    logic        rst_i = 1;
    logic        cyc = 0, stb = 0, we = 0, c1cnt = 0, p = 0, ini, ex;
    logic [7:0]  adr = 0;
    logic [31:0] dat = 0, rd_v;
    logic [79:0] cnt = 0;
    logic [15:0] ext = 0;
    wire  [31:0] dat_o;
    wire         ack;
    wire  [15:0] pin_i, pin_o, pin_oe, flag;
    wire  [4:0]  start;
    integer      miscompares = 0, num_checks = 0, i;
    always #25 clk_i = ~clk_i;
    timer_io_control_capture_compare timer_io_control_capture_compare_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .cnt_i(cnt),
        .ch1_count_i(c1cnt), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe), .counter_start_o(start), .flag_o(flag));
    pin_far_end pin_far_end_inst (.pin_o(pin_o), .pin_oe_o(pin_oe),
        .ext_i(ext), .pin_i(pin_i));
    task step(input integer k);
        repeat (k) @(posedge clk_i);
    endtask
    // The watchdog bounds this wait; the slave may answer at any time.
    task bus_wait;
        do @(posedge clk_i); while (ack !== 1'b1);
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {3'b111, a, d};
        bus_wait;
        {cyc, stb, we} <= 3'b000;
    endtask
    task rd(input [7:0] a);
        @(posedge clk_i);
        {cyc, stb, we, adr} <= {3'b110, a};
        bus_wait;
        rd_v = dat_o;
        {cyc, stb} <= 2'b00;
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task pulse;
        cnt[31:16] <= 16'h0005;
        @(posedge clk_i);
        cnt[31:16] <= 16'h0000;
        step(2);
    endtask
    task summarize;
        if (miscompares == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        step(30000);
        miscompares++;
        summarize;
    end
    initial begin
        step(6);
        rst_i <= 0;
        chk("rst_pin", 2'b10, {pin_oe[0], pin_o[0]});
        for (i = 0; i < 8; i++) begin
            rd(4 * i);
            chk("io_rst", 0, rd_v);
            wr(4 * i, 8'h5a + i);
            rd(4 * i);
            chk("io_rw", 8'h5a + i, rd_v);
            wr(4 * i, 0);
        end
        wr(8'hfc, 32'hffff);
        rd(8'hfc);
        chk("unmapped", 0, rd_v);
        wr(8'h50, 16'h0005);
        for (i = 0; i < 8; i++) begin
            wr(8'h34, 0);
            wr(8'h04, i);
            step(3);
            ini = (i[1:0] == 0) ? p : i[2];
            chk("init", ini, pin_o[4]);
            pulse;
            chk("stopped", ini, pin_o[4]);
            wr(8'h34, 32'h2);
            pulse;
            ex = i[1:0] == 1 ? 0 : i[1:0] == 2 ? 1 : i[1:0] == 3 ? !ini : ini;
            chk("match", ex, pin_o[4]);
            chk("mflag", 1, flag[4]);
            wr(8'h38, 32'hffff);
            p = ini;
        end
        wr(8'h34, 0);
        wr(8'h24, 8'h03);
        wr(8'h04, 8'h05);
        wr(8'h34, 32'h2);
        chk("start", 5'h02, start);
        cnt[31:16] <= 16'h0005;
        step(2);
        chk("pwm2_match", 0, pin_o[4]);
        cnt[31:16] <= 16'h0000;
        step(2);
        chk("pwm2_zero", 1, pin_o[4]);
        wr(8'h34, 0);
        wr(8'h24, 8'h00);
        for (i = 8; i < 12; i++) begin
            cnt[31:16] <= 16'h0100 + i;
            ext[4] <= 0;
            wr(8'h04, i);
            step(6);
            wr(8'h38, 32'hffff);
            ext[4] <= 1;
            step(6);
            chk("rise", i != 9, flag[4]);
            rd(8'h50);
            if (i != 9) chk("cap", 16'h0100 + i, rd_v);
            wr(8'h38, 32'hffff);
            ext[4] <= 0;
            step(6);
            chk("fall", i != 8, flag[4]);
        end
        cnt[15:0] <= 16'h0abc;
        wr(8'h00, 8'h0c);
        wr(8'h04, 8'h0c);
        step(6);
        wr(8'h38, 32'hffff);
        c1cnt <= 1;
        @(posedge clk_i);
        c1cnt <= 0;
        step(3);
        chk("ch1src", 1, flag[0]);
        chk("ch1src_other", 0, flag[4]);
        rd(8'h40);
        chk("ch1cap", 16'h0abc, rd_v);
        wr(8'h20, 8'h30);
        rd(8'h20);
        chk("mode", 8'hf0, rd_v);
        wr(8'h14, 8'h88);
        step(6);
        wr(8'h38, 32'hffff);
        ext[3:2] <= 2'b11;
        step(6);
        chk("buf_off", 0, flag[3:2]);
        cnt[15:0] <= 16'h0def;
        wr(8'h00, 8'h08);
        step(6);
        ext[0] <= 1;
        step(6);
        rd(8'h48);
        chk("buf_copy", 16'h0abc, rd_v);
        rd(8'h40);
        chk("buf_cap", 16'h0def, rd_v);
        summarize;
    end
endmodule // testbench
`default_nettype wire
